// File: hw/time_packet_defines.svh
// constants for the time data packet builder: codes, field positions, timing
`ifndef TIME_PACKET_DEFINES_SVH
`define TIME_PACKET_DEFINES_SVH

// ====================================================================
// channel-specific word fields
`define CSW_LAYOUT_BIT 9
`define CSW_LEAP_BIT 8
`define CSW_FORMAT_LSB 4
`define CSW_SOURCE_LSB 0
`define CSW_RESET_VALUE 32'h0000_0000

// ====================================================================
// time format codes
`define TIME_FORMAT_RANGE_B 4'h0
`define TIME_FORMAT_RANGE_A 4'h1
`define TIME_FORMAT_RANGE_G 4'h2
`define TIME_FORMAT_RELATIVE 4'h3
`define TIME_FORMAT_SAT_UTC 4'h4
`define TIME_FORMAT_SAT_NATIVE 4'h5
`define TIME_FORMAT_NONE 4'hF

// ====================================================================
// time source codes
`define TIME_SOURCE_INTERNAL 4'h0
`define TIME_SOURCE_EXTERNAL 4'h1
`define TIME_SOURCE_MEM_MODULE 4'h2
`define TIME_SOURCE_NONE 4'hF

// ====================================================================
// timing
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 10000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_SECOND 100

// ====================================================================
// packet word positions
`define IDX_CSW_LO 4'h3
`define IDX_BODY0 4'h5
`define IDX_LAST_DOY 4'h7
`define IDX_LAST_DMY 4'h8

`endif

// File: hw/time_packet_pkg.sv
// types shared by the time data packet builder
package time_packet_pkg;

  // ====================================================================
  // kind of word on the output stream
  typedef enum logic [1:0] {
    KIND_RTC = 2'h0,
    KIND_CSW = 2'h1,
    KIND_BODY = 2'h2
  } word_kind_t;

  typedef struct packed {
    logic sop;
    logic eop;
    word_kind_t kind;
    logic [15:0] data;
  } stream_word_t;

  // ====================================================================
  // time of day and date as decimal digits
  typedef struct packed {
    logic [3:0] tens_of_ms_digit;
    logic [3:0] hundreds_of_ms_digit;
    logic [3:0] seconds_digit;
    logic [2:0] tens_of_seconds_digit;
    logic [3:0] minutes_digit;
    logic [2:0] tens_of_minutes_digit;
    logic [3:0] hours_digit;
    logic [1:0] tens_of_hours_digit;
    logic [3:0] days_digit;
    logic [3:0] tens_of_days_digit;
    logic [1:0] hundreds_of_days_digit;
    logic [3:0] months_digit;
    logic tens_of_months_digit;
    logic [3:0] years_digit;
    logic [3:0] tens_of_years_digit;
    logic [3:0] hundreds_of_years_digit;
    logic [1:0] thousands_of_years_digit;
  } time_bcd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } build_state_t;

endpackage

// File: hw/time_data_packet_builder.sv
// time data packet builder: samples the relative counter and time, emits packet words
`include "time_packet_defines.svh"

// Behaviour
// R1: with any source but none, a time packet leaves at least once a second.
// R2: range time-code formats sample the relative counter at the reference pulse.
// R3: other formats sample the relative counter on the 10 ms grid.
// R4: a time packet is the first dynamic packet of each recording.
// R5: with source none, one time packet still starts the recording.
// R6: packet order is counter sample, channel-specific word, time words; no per-item headers.
// R7: channel-specific word: reserved 31-12, layout 11-8, format 7-4, source 3-0.
// R8: bits 11-10 zero; bit 9 selects day-of-year or day-month-year body.
// R9: bit 8 shows the leap-year flag.
// R10: format field carries the selected format code, 0xF meaning none.
// R11: source field carries internal, external, memory module or none codes.
// R12: external source without lock reports internal until lock returns.
// R13: time words carry every digit in binary-coded decimal.
// R14: day-of-year body is three words with the fixed digit positions.
// R15: day-month-year body adds month and year digits in words three and four.
// R16: units digits are limited to 0-9; narrow fields keep their width.
// R17: with format none the word and body are still emitted.
module time_data_packet_builder #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int TICKS_PER_SECOND = `TICKS_PER_SECOND
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration
  input wire logic [3:0] time_format_field,
  input wire logic [3:0] time_source_select,
  input wire logic layout_day_month_year,
  input wire logic leap_year,
  input wire logic external_lock,
  // time inputs
  input wire logic [47:0] relative_time_count,
  input wire logic time_code_ref_pulse,
  input wire time_packet_pkg::time_bcd_t time_now,
  // recording control
  input wire logic recording_start,
  output logic time_first_pending,
  // packet word stream
  output logic word_valid,
  input wire logic word_ready,
  output time_packet_pkg::stream_word_t word_out
);

  // ====================================================================
  // helpers
  // out-of-range units digits clamp to nine rather than leak a non-decimal code
  function automatic logic [3:0] units_digit(input logic [3:0] d);
    units_digit = (d > 4'h9) ? 4'h9 : d; // [R16]
  endfunction

  function automatic logic is_range_format(input logic [3:0] f);
    is_range_format = (f == `TIME_FORMAT_RANGE_B) ||
                      (f == `TIME_FORMAT_RANGE_A) ||
                      (f == `TIME_FORMAT_RANGE_G);
  endfunction

  // widths follow the counts, so a short grid in simulation needs no other edit
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int SEC_W = $clog2(TICKS_PER_SECOND + 1);

  // ====================================================================
  // state
  // one-hot codes; the case needs no default as the enum holds only these two
  time_packet_pkg::build_state_t state_reg, state_next;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [SEC_W-1:0] since_cnt_reg;
  logic first_pending_reg;
  logic [47:0] rtc_smp_reg;
  time_packet_pkg::time_bcd_t time_smp_reg;
  logic [31:0] csw_reg;
  logic dmy_reg;
  logic [3:0] idx_reg;
  time_packet_pkg::stream_word_t out_reg, skid_reg;
  logic out_valid_reg, skid_valid_reg;

  // ====================================================================
  // sample instants and packet triggers
  wire tick_10ms = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  wire range_format = is_range_format(time_format_field);
  wire source_active = (time_source_select != `TIME_SOURCE_NONE);
  wire late = (since_cnt_reg >= SEC_W'(TICKS_PER_SECOND - 1));
  wire want = source_active | first_pending_reg; // [R5]
  // range formats use the reference pulse; the 1 s fallback covers a missing pulse
  wire ref_hit = range_format & time_code_ref_pulse & want; // [R2]
  // other formats start only on the grid: at the next tick for a new recording, else when late
  wire tick_first = first_pending_reg & ~range_format; // [R4] [R5]
  wire tick_late = want & late; // [R1]
  wire tick_hit = tick_10ms & (tick_first | tick_late); // [R1] [R3]
  wire start = (state_reg == time_packet_pkg::ST_IDLE) & (ref_hit | tick_hit);

  // ====================================================================
  // channel-specific word
  // lock is read live, so the field is external again in the first packet after lock returns
  wire [3:0] source_reported = (time_source_select == `TIME_SOURCE_EXTERNAL && !external_lock) ?
                               `TIME_SOURCE_INTERNAL : time_source_select; // [R12] [R11]
  // bits 11-10 stay zero; only the layout and leap-year flags fill the date nibble
  wire [31:0] csw_layout = 32'(layout_day_month_year) << `CSW_LAYOUT_BIT; // [R8]
  wire [31:0] csw_leap = 32'(leap_year) << `CSW_LEAP_BIT; // [R9]
  wire [31:0] csw_format = 32'(time_format_field) << `CSW_FORMAT_LSB; // [R10]
  wire [31:0] csw_source = 32'(source_reported) << `CSW_SOURCE_LSB; // [R7]
  wire [31:0] csw_next = `CSW_RESET_VALUE | csw_layout | csw_leap | csw_format | csw_source;

  // ====================================================================
  // body words, digits in binary-coded decimal
  wire [15:0] body_w1 = {1'b0, time_smp_reg.tens_of_seconds_digit, units_digit(time_smp_reg.seconds_digit),
                         units_digit(time_smp_reg.hundreds_of_ms_digit),
                         units_digit(time_smp_reg.tens_of_ms_digit)}; // [R13] [R14]
  wire [15:0] body_w2 = {2'b00, time_smp_reg.tens_of_hours_digit, units_digit(time_smp_reg.hours_digit),
                         1'b0, time_smp_reg.tens_of_minutes_digit, units_digit(time_smp_reg.minutes_digit)}; // [R14]
  wire [15:0] body_w3_doy = {6'h00, time_smp_reg.hundreds_of_days_digit,
                             units_digit(time_smp_reg.tens_of_days_digit),
                             units_digit(time_smp_reg.days_digit)}; // [R14]
  wire [15:0] body_w3_dmy = {3'h0, time_smp_reg.tens_of_months_digit, units_digit(time_smp_reg.months_digit),
                             units_digit(time_smp_reg.tens_of_days_digit),
                             units_digit(time_smp_reg.days_digit)}; // [R15]
  wire [15:0] body_w4 = {2'b00, time_smp_reg.thousands_of_years_digit,
                         units_digit(time_smp_reg.hundreds_of_years_digit),
                         units_digit(time_smp_reg.tens_of_years_digit),
                         units_digit(time_smp_reg.years_digit)}; // [R15]

  // ====================================================================
  // word selection: counter sample, word, body, in that order
  wire [3:0] last_idx = dmy_reg ? `IDX_LAST_DMY : `IDX_LAST_DOY;
  // counter sample goes low word first; the multiplexer builds its header from it
  wire [15:0] rtc_word = (idx_reg == 4'h0) ? rtc_smp_reg[15:0] :
                         (idx_reg == 4'h1) ? rtc_smp_reg[31:16] : rtc_smp_reg[47:32];
  wire [15:0] csw_word = (idx_reg == `IDX_CSW_LO) ? csw_reg[15:0] : csw_reg[31:16];
  wire [15:0] body_w3 = dmy_reg ? body_w3_dmy : body_w3_doy;
  wire [15:0] body_word = (idx_reg == `IDX_BODY0) ? body_w1 :
                          (idx_reg == 4'h6) ? body_w2 :
                          (idx_reg == 4'h7) ? body_w3 : body_w4;
  wire is_rtc = (idx_reg < `IDX_CSW_LO);
  wire is_csw = (idx_reg < `IDX_BODY0) & ~is_rtc;
  time_packet_pkg::stream_word_t cur_word;
  assign cur_word.sop = (idx_reg == 4'h0);
  assign cur_word.eop = (idx_reg == last_idx);
  assign cur_word.kind = is_rtc ? time_packet_pkg::KIND_RTC :
                         is_csw ? time_packet_pkg::KIND_CSW : time_packet_pkg::KIND_BODY; // [R6]
  assign cur_word.data = is_rtc ? rtc_word : is_csw ? csw_word : body_word; // [R6]

  // ====================================================================
  // builder control
  // the builder waits only while the skid stage is full, so no pushed word is dropped
  wire buf_ready = ~skid_valid_reg;
  wire push = (state_reg == time_packet_pkg::ST_SEND) & buf_ready;
  wire done = push & cur_word.eop;

  // a trigger while sending is dropped; the saturated since-count retriggers on the next tick
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      time_packet_pkg::ST_IDLE: begin
        if (start) begin
          state_next = time_packet_pkg::ST_SEND;
        end
      end
      time_packet_pkg::ST_SEND: begin
        if (done) begin
          state_next = time_packet_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= time_packet_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // the index restarts on every packet, so nothing of an older packet carries over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= 4'h0;
    end else if (clk_en) begin
      if (start) begin
        idx_reg <= 4'h0;
      end else if (push) begin
        idx_reg <= idx_reg + 4'h1;
      end
    end
  end

  // ====================================================================
  // 10 ms grid and time since the last packet
  // the grid runs from reset regardless of recordings, so every sample outside the range formats lands on it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (clk_en) begin
      tick_cnt_reg <= tick_10ms ? '0 : tick_cnt_reg + TICK_W'(1);
    end
  end

  // saturates at the one-second mark, so a long stall cannot wrap it back to early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_cnt_reg <= '0;
    end else if (clk_en) begin
      if (start) begin
        since_cnt_reg <= '0;
      end else if (tick_10ms && !late) begin
        since_cnt_reg <= since_cnt_reg + SEC_W'(1); // [R1]
      end
    end
  end

  // ====================================================================
  // recording start holds back dynamic packets until the time packet is out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_pending_reg <= 1'b0;
    end else if (clk_en) begin
      // a new recording start beats a packet start in the same cycle
      if (recording_start) begin
        first_pending_reg <= 1'b1; // [R4]
      end else if (start) begin
        first_pending_reg <= 1'b0;
      end
    end
  end

  // cleared only once the last word of the packet started after the recording start is pushed into the output buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_first_pending <= 1'b0;
    end else if (clk_en) begin
      if (recording_start) begin
        time_first_pending <= 1'b1; // [R4]
      end else if (done && !first_pending_reg) begin
        time_first_pending <= 1'b0;
      end
    end
  end

  // ====================================================================
  // capture at the sample instant; format none still yields a full packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_smp_reg <= 48'h0000_0000_0000;
      time_smp_reg <= '0;
    end else if (clk_en && start) begin
      rtc_smp_reg <= relative_time_count; // [R2] [R3]
      time_smp_reg <= time_now;
    end
  end

  // frozen with the sample, so a setting changed mid-packet cannot mix two words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csw_reg <= `CSW_RESET_VALUE;
      dmy_reg <= 1'b0;
    end else if (clk_en && start) begin
      csw_reg <= csw_next; // [R17]
      dmy_reg <= layout_day_month_year; // [R8]
    end
  end

  // ====================================================================
  // two-entry buffer: output stage plus skid stage, so a stall loses no word
  wire out_take = ~out_valid_reg | word_ready;
  wire skid_load = ~out_take & push;

  // output stage: a parked skid word goes first, so word order is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else if (clk_en && out_take) begin
      out_reg <= skid_valid_reg ? skid_reg : cur_word;
      out_valid_reg <= skid_valid_reg | push;
    end
  end

  // skid stage: catches the word pushed in the cycle the consumer stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skid_reg <= '0;
      skid_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (skid_load) begin
        skid_reg <= cur_word;
        skid_valid_reg <= 1'b1;
      end else if (out_take) begin
        skid_valid_reg <= 1'b0;
      end
    end
  end

  assign word_valid = out_valid_reg;
  assign word_out = out_reg;

endmodule

// File: sim/packet_sink.sv
// packet word sink standing in for the recorder multiplexer
module packet_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stall request from the bench
  input wire logic stall,
  // packet word stream
  input wire logic word_valid,
  input wire time_packet_pkg::stream_word_t word_out,
  output logic word_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  time_packet_pkg::stream_word_t got[$];
  // ready is registered, so a stall lands one cycle late, as a real multiplexer's would
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ready <= 1'b0;
    end else begin
      word_ready <= !stall;
      if (word_valid && word_ready) got.push_back(word_out);
    end
  end
endmodule

// File: sim/time_packet_chk.sv
// port checks for the time data packet builder
module time_packet_chk #(
  parameter int TICK_CYCLES = 20,
  parameter int TICKS_PER_SECOND = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [3:0] time_source_select,
  input wire logic recording_start,
  input wire logic time_first_pending,
  // stream
  input wire logic word_valid,
  input wire logic word_ready,
  input wire time_packet_pkg::stream_word_t word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================================================================
  // gap between accepted packet starts: one second plus room for a short consumer stall
  int gap_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap_cnt <= 0;
    else if (time_source_select == 4'hF || (word_valid && word_ready && word_out.sop)) gap_cnt <= 0;
    else gap_cnt <= gap_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_csw; word_valid && word_out.kind == time_packet_pkg::KIND_CSW; endsequence
  sequence s_body; word_valid && word_out.kind == time_packet_pkg::KIND_BODY; endsequence
  a_stall_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_out))
    else $error("word moved in stall");
  a_csw_reserved: assert property (s_csw |-> word_out.data[15:10] == 6'h00)
    else $error("reserved bits set");
  a_body_msb: assert property (s_body |-> !word_out.data[15])
    else $error("body bit 15 set");
  a_units_digit: assert property (s_body |-> word_out.data[3:0] <= 4'h9 && word_out.data[11:8] <= 4'h9)
    else $error("digit above nine");
  a_sop_counter: assert property (word_valid && word_out.sop |-> word_out.kind == time_packet_pkg::KIND_RTC)
    else $error("bad first word");
  a_eop_body: assert property (word_valid && word_out.eop |-> s_body)
    else $error("bad last word");
  a_first_set: assert property (recording_start |=> time_first_pending)
    else $error("first not pending");
  a_second_gap: assert property (gap_cnt <= TICK_CYCLES * TICKS_PER_SECOND + 40)
    else $error("packets too sparse");
endmodule
bind time_data_packet_builder time_packet_chk #(.TICK_CYCLES(TICK_CYCLES), .TICKS_PER_SECOND(TICKS_PER_SECOND)) i_chk (
  .clk(clk), .rst_n(rst_n), .time_source_select(time_source_select), .recording_start(recording_start),
  .time_first_pending(time_first_pending), .word_valid(word_valid), .word_ready(word_ready), .word_out(word_out));

// File: sim/test_time_data_packet_builder.sv
// bench for the time data packet builder
module test_time_data_packet_builder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, stall, wv, wr, pend;
  logic rst_n = 1'b0, ref_p = 1'b0, rec = 1'b0, dm = 1'b0, lp = 1'b0, lk = 1'b1;
  logic [3:0] f = 4'h3, s = 4'h1;
  logic [47:0] rtc = 48'h5A5A_3C3C_0000, grid = 48'h0, r, rexp;
  time_packet_pkg::time_bcd_t t = '{4'h7, 4'h4, 4'hC, 3'h5, 4'h8, 3'h2, 4'h3, 2'h1, 4'h6, 4'h2, 2'h3,
                                    4'h9, 1'h1, 4'h5, 4'h1, 4'h0, 2'h2};
  time_packet_pkg::stream_word_t wo;
  int error_cnt = 0;
  int samples_checked = 0;
  // four stalled cycles in sixteen are enough to fill the two-entry buffer
  assign stall = rtc[3:2] == 2'b00;
  always @(posedge clk) rtc <= rtc + 48'h1;
  time_data_packet_builder #(.TICK_CYCLES(20), .TICKS_PER_SECOND(5)) i_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .time_format_field(f), .time_source_select(s),
    .layout_day_month_year(dm), .leap_year(lp), .external_lock(lk), .relative_time_count(rtc),
    .time_code_ref_pulse(ref_p), .time_now(t), .recording_start(rec), .time_first_pending(pend),
    .word_valid(wv), .word_ready(wr), .word_out(wo));
  packet_sink i_sink (.clk(clk), .rst_n(rst_n), .stall(stall), .word_valid(wv), .word_out(wo), .word_ready(wr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====================================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_for(input bit eop);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (eop ? (wv && wr && wo.eop) === 1'b1 : pend === 1'b0) return;
    end
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask
  function automatic logic [3:0] cl(input logic [3:0] d);
    return d > 4'h9 ? 4'h9 : d;
  endfunction
  // new recording with one setting; the last whole packet seen is the first one of it
  task automatic run(input logic [3:0] fc, input logic [3:0] sc, input logic k, input logic d, input logic y,
                     input logic [3:0] se);
    logic [15:0] w[9];
    int n;
    wait_for(1'b1);
    f <= fc;
    s <= sc;
    lk <= k;
    dm <= d;
    lp <= y;
    rec <= 1'b1;
    @(posedge clk);
    rec <= 1'b0;
    if (fc < 4'h3) begin
      @(posedge clk);
      ref_p <= 1'b1;
      @(posedge clk);
      rexp = rtc;
      ref_p <= 1'b0;
    end
    wait_for(1'b0);
    repeat (16) @(posedge clk);
    n = i_sink.got.size() - 1;
    while (n > 0 && i_sink.got[n].eop !== 1'b1) n--;
    n -= d ? 8 : 7;
    for (int j = 0; j < (d ? 9 : 8); j++) w[j] = i_sink.got[n + j].data;
    r = {w[2], w[1], w[0]};
    chk({15'h0, i_sink.got[n].sop}, 16'h0001);
    chk({15'h0, i_sink.got[n + (d ? 8 : 7)].eop}, 16'h0001);
    if (fc < 4'h3) for (int j = 0; j < 3; j++) chk(w[j], rexp[16*j +: 16]);
    else if (grid !== 48'h0) chk(16'((r - grid) % 20), 16'h0000);
    chk(w[3], {6'h00, d, y, fc, se});
    chk(w[4], 16'h0000);
    chk(w[5], {1'b0, t.tens_of_seconds_digit, cl(t.seconds_digit), cl(t.hundreds_of_ms_digit),
               cl(t.tens_of_ms_digit)});
    chk(w[6], {2'b00, t.tens_of_hours_digit, cl(t.hours_digit), 1'b0, t.tens_of_minutes_digit,
               cl(t.minutes_digit)});
    if (d) begin
      chk(w[7], {3'b000, t.tens_of_months_digit, cl(t.months_digit), t.tens_of_days_digit, cl(t.days_digit)});
      chk(w[8], {2'b00, t.thousands_of_years_digit, cl(t.hundreds_of_years_digit), t.tens_of_years_digit,
                 cl(t.years_digit)});
    end else begin
      chk(w[7], {6'h00, t.hundreds_of_days_digit, t.tens_of_days_digit, cl(t.days_digit)});
    end
  endtask
  // ====================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(4'h3, 4'h1, 1'b1, 1'b0, 1'b1, 4'h1);
    grid = r;
    run(4'h3, 4'h1, 1'b0, 1'b1, 1'b0, 4'h0);
    run(4'h4, 4'h1, 1'b1, 1'b1, 1'b1, 4'h1);
    run(4'h5, 4'h2, 1'b0, 1'b0, 1'b0, 4'h2);
    run(4'h0, 4'h0, 1'b1, 1'b0, 1'b1, 4'h0);
    run(4'h1, 4'h2, 1'b1, 1'b1, 1'b0, 4'h2);
    run(4'h2, 4'h1, 1'b1, 1'b0, 1'b0, 4'h1);
    run(4'hF, 4'hF, 1'b1, 1'b1, 1'b1, 4'hF);
    stop_test();
  end
endmodule
